//--- verilog/acc_cmd_tail.sv
// Configuration and housekeeping part of an ASCII command interpreter.
// Assumes byte streams from a UART on clk and a nonvolatile store whose
// read data is stable from reset onward.
//
// Overview of operation
// - Command d replies with temperature and supply voltage readings.
// - Command W copies all parameters to storage, then confirms.
// - After reset, load stored parameters if enabled, else factory defaults.
// - Command E toggles use of stored values and names the new state.
// - Command Y takes 0..9: echo, no echo, or RS485 with delay.
// - Command Z takes 33..255 as address letter; host must save it.
// - Command ? lists commands, ranges and current setting values.
// - With RS232 active, a revision banner is sent after reset.
// - Distinct messages for overcurrent, overtemperature, undervoltage.
`timescale 1ns/1ns
module acc_cmd_tail (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    output logic rxReady,
    output logic [7:0] txData,
    output logic txValid,
    input wire logic txReady,
    input wire logic [7:0] tempAdc,
    input wire logic [7:0] voltAdc,
    input wire logic overCurrent,
    input wire logic overTemp,
    input wire logic underVolt,
    input wire acc_pkg::acc_param_t nvRdData,
    output acc_pkg::acc_param_t nvWrData,
    output logic nvWrite,
    output logic nvFlagWrite,
    output acc_pkg::acc_param_t linkCfg,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData
);

    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_BOOT = 2'b01,
        ST_RUN = 2'b10
    } acc_state_t;

    acc_state_t state_q;
    acc_pkg::acc_param_t prm_q;
    acc_pkg::acc_param_t nvWrData_q;
    acc_pkg::acc_vals_t vals;
    acc_pkg::acc_msg_t msg_q;
    logic [15:0] rev_q;
    logic [acc_pkg::NUM_MSG-1:0] pend_q;
    logic [acc_pkg::NUM_MSG-1:0] pendSet;
    logic [acc_pkg::NUM_MSG-1:0] pendClr;
    logic [5:0] idx_q;
    logic active_q;
    logic txValid_q;
    logic [7:0] txData_q;
    logic echoPend_q;
    logic [7:0] echoByte_q;
    logic rxReady_q;
    logic nvWrite_q;
    logic nvFlagWrite_q;
    logic [31:0] regRdData_q;
    logic argOn_q;
    logic argHas_q;
    logic [7:0] argCmd_q;
    logic [9:0] argVal_q;
    logic [2:0] errMeta_q, errSync_q, errPrev_q;
    logic [2:0] errRise;
    logic [7:0] txCh;
    logic txLast;
    logic txFree;
    logic startMsg;
    logic echoSend;
    logic rxTake;
    logic isDigit;
    logic endArg;
    logic newCmd;
    logic argOk;
    logic cmdSave;
    logic cmdToggle;
    logic ifaceWr;
    logic addrWr;
    logic [3:0] pendSel;
    logic [13:0] argNext;

    // Lowest pending message index
    function automatic logic [3:0] firstSet(
        input logic [acc_pkg::NUM_MSG-1:0] v
    );
        logic [3:0] r;
        r = 4'h0;
        for (int i = acc_pkg::NUM_MSG - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    assign vals = '{temp: tempAdc, volt: voltAdc, revMaj: rev_q[15:8],
                    revMin: rev_q[7:0], prm: prm_q};

    acc_text u_text (
        .msgId(msg_q),
        .idx(idx_q),
        .vals(vals),
        .ch(txCh),
        .last(txLast)
    );

    // Command parsing
    assign rxTake = rxValid && rxReady_q;
    assign isDigit = rxData >= acc_pkg::CH_ZERO && rxData <= acc_pkg::CH_NINE;
    assign endArg = rxTake && argOn_q && !isDigit;
    assign newCmd = rxTake && !(argOn_q && isDigit);
    assign argNext = argVal_q * 14'h00a + 14'(rxData - acc_pkg::CH_ZERO);
    assign errRise = errSync_q & ~errPrev_q;

    always_comb
    begin
        argOk = 1'b0;
        if (argCmd_q == acc_pkg::CH_IFACE)
        begin
            argOk = argVal_q <= 10'(acc_pkg::IFACE_MAX);
        end
        else
        begin
            argOk = argVal_q >= 10'(acc_pkg::ADDR_MIN) &&
                    argVal_q <= 10'h0ff;
        end
        argOk = argOk && argHas_q;
        ifaceWr = endArg && argOk && argCmd_q == acc_pkg::CH_IFACE;
        addrWr = endArg && argOk && argCmd_q == acc_pkg::CH_ADDR;
        cmdSave = newCmd && rxData == acc_pkg::CH_SAVE;
        cmdToggle = newCmd && rxData == acc_pkg::CH_ENA;
    end

    always_comb
    begin
        pendSet = '0;
        pendSet[acc_pkg::MSG_ADC] = newCmd && rxData == acc_pkg::CH_ADC;
        pendSet[acc_pkg::MSG_WRITE] = cmdSave;
        pendSet[acc_pkg::MSG_ENA] = cmdToggle && !prm_q.storeEn;
        pendSet[acc_pkg::MSG_DIS] = cmdToggle && prm_q.storeEn;
        pendSet[acc_pkg::MSG_HELP] = newCmd && rxData == acc_pkg::CH_HELP;
        pendSet[acc_pkg::MSG_OVL] = errRise[0];
        pendSet[acc_pkg::MSG_OVT] = errRise[1];
        pendSet[acc_pkg::MSG_UVL] = errRise[2];
        pendSet[acc_pkg::MSG_BANNER] = state_q == ST_BOOT &&
            prm_q.iface <= acc_pkg::IFACE_NOECHO;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            argOn_q <= 1'b0;
            argHas_q <= 1'b0;
            argCmd_q <= 8'h00;
            argVal_q <= 10'h000;
        end
        else if (rxTake)
        begin
            if (argOn_q && isDigit)
            begin
                argHas_q <= 1'b1;
                argVal_q <= argNext > 14'(acc_pkg::ARG_SAT) ?
                    acc_pkg::ARG_SAT : argNext[9:0];
            end
            else
            begin
                argOn_q <= rxData == acc_pkg::CH_IFACE ||
                           rxData == acc_pkg::CH_ADDR;
                argCmd_q <= rxData;
                argHas_q <= 1'b0;
                argVal_q <= 10'h000;
            end
        end
    end

    // Boot sequence and settings
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q <= ST_LOAD;
        end
        else
        begin
            unique case (state_q)
                ST_LOAD: state_q <= ST_BOOT;
                ST_BOOT: state_q <= ST_RUN;
                ST_RUN: state_q <= ST_RUN;
                default: state_q <= ST_LOAD;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            prm_q <= '{1'b0, acc_pkg::IFACE_DEFAULT, acc_pkg::ADDR_DEFAULT};
            rev_q <= {acc_pkg::REV_MAJOR_RST, acc_pkg::REV_MINOR_RST};
        end
        else if (state_q == ST_LOAD)
        begin
            prm_q.storeEn <= nvRdData.storeEn;
            if (nvRdData.storeEn)
            begin
                prm_q <= nvRdData;
            end
        end
        else if (regWr && regAddr == acc_pkg::ADDR_CFG)
        begin
            if (regWrData[3:0] <= acc_pkg::IFACE_MAX)
            begin
                prm_q.iface <= regWrData[3:0];
            end
            if (regWrData[acc_pkg::CFG_ADDR_LSB +: 8] >= acc_pkg::ADDR_MIN)
            begin
                prm_q.addr <= regWrData[acc_pkg::CFG_ADDR_LSB +: 8];
            end
            prm_q.storeEn <= regWrData[acc_pkg::CFG_EN_BIT];
        end
        else if (regWr && regAddr == acc_pkg::ADDR_REV)
        begin
            rev_q <= regWrData[15:0];
        end
        else
        begin
            if (ifaceWr)
            begin
                prm_q.iface <= argVal_q[3:0];
            end
            if (addrWr)
            begin
                prm_q.addr <= argVal_q[7:0];
            end
            if (cmdToggle)
            begin
                prm_q.storeEn <= !prm_q.storeEn;
            end
        end
    end

    // Storage writes
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            nvWrite_q <= 1'b0;
            nvFlagWrite_q <= 1'b0;
            nvWrData_q <= '0;
        end
        else
        begin
            nvWrite_q <= cmdSave;
            nvFlagWrite_q <= cmdToggle;
            if (cmdSave)
            begin
                nvWrData_q <= prm_q;
            end
            else if (cmdToggle)
            begin
                nvWrData_q <= '{!prm_q.storeEn, prm_q.iface, prm_q.addr};
            end
        end
    end

    // Message transmit
    localparam logic [acc_pkg::NUM_MSG-1:0] NUM_ONE = 9'h001;
    assign txFree = !txValid_q || txReady;
    assign startMsg = txFree && !active_q && !echoPend_q && |pend_q;
    assign echoSend = txFree && !active_q && echoPend_q;
    assign pendSel = firstSet(pend_q);
    assign pendClr = startMsg ? NUM_ONE << pendSel : '0;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            pend_q <= '0;
            errMeta_q <= 3'h0;
            errSync_q <= 3'h0;
            errPrev_q <= 3'h0;
            echoPend_q <= 1'b0;
            echoByte_q <= 8'h00;
        end
        else
        begin
            pend_q <= (pend_q & ~pendClr) | pendSet;
            errMeta_q <= {underVolt, overTemp, overCurrent};
            errSync_q <= errMeta_q;
            errPrev_q <= errSync_q;
            if (rxTake && prm_q.iface == acc_pkg::IFACE_DEFAULT)
            begin
                echoPend_q <= 1'b1;
                echoByte_q <= rxData;
            end
            else if (echoSend)
            begin
                echoPend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            active_q <= 1'b0;
            msg_q <= acc_pkg::MSG_BANNER;
            idx_q <= 6'h00;
            txValid_q <= 1'b0;
            txData_q <= 8'h00;
        end
        else if (txFree)
        begin
            txValid_q <= active_q || echoPend_q;
            if (active_q)
            begin
                txData_q <= txCh;
                idx_q <= idx_q + 6'h01;
                active_q <= !txLast;
            end
            else if (echoPend_q)
            begin
                txData_q <= echoByte_q;
            end
            else if (startMsg)
            begin
                active_q <= 1'b1;
                msg_q <= acc_pkg::acc_msg_t'(pendSel);
                idx_q <= 6'h00;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rxReady_q <= 1'b0;
        end
        else
        begin
            rxReady_q <= state_q == ST_RUN && !rxTake && !active_q &&
                !startMsg && !echoPend_q && (pend_q | pendSet) == '0;
        end
    end

    // Register read port
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            regRdData_q <= 32'h0000_0000;
        end
        else if (regRd)
        begin
            regRdData_q <= 32'h0000_0000;
            unique case (regAddr)
                acc_pkg::ADDR_STATUS:
                begin
                    regRdData_q[3:0] <= prm_q.iface;
                    regRdData_q[acc_pkg::ST_EN_BIT] <= prm_q.storeEn;
                    regRdData_q[acc_pkg::ST_BUSY_BIT] <= active_q;
                    regRdData_q[acc_pkg::ST_PEND_LSB +: acc_pkg::NUM_MSG]
                        <= pend_q;
                end
                acc_pkg::ADDR_CFG:
                begin
                    regRdData_q[3:0] <= prm_q.iface;
                    regRdData_q[acc_pkg::CFG_ADDR_LSB +: 8] <= prm_q.addr;
                    regRdData_q[acc_pkg::CFG_EN_BIT] <= prm_q.storeEn;
                end
                acc_pkg::ADDR_REV: regRdData_q[15:0] <= rev_q;
                default: regRdData_q <= 32'h0000_0000;
            endcase
        end
    end

    assign rxReady = rxReady_q;
    assign txData = txData_q;
    assign txValid = txValid_q;
    assign nvWrData = nvWrData_q;
    assign nvWrite = nvWrite_q;
    assign nvFlagWrite = nvFlagWrite_q;
    assign linkCfg = prm_q;
    assign regRdData = regRdData_q;

endmodule // acc_cmd_tail

//--- verilog/acc_pkg.sv
// Shared constants, types and message texts of the command tail.
// Assumes a single 100 MHz clock domain and byte-wide serial streams.
package acc_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_REV = 8'h08;

    // Field positions
    localparam int CFG_ADDR_LSB = 8;
    localparam int CFG_EN_BIT = 16;
    localparam int ST_EN_BIT = 4;
    localparam int ST_BUSY_BIT = 5;
    localparam int ST_PEND_LSB = 6;

    // Setting ranges and reset values
    localparam logic [3:0] IFACE_DEFAULT = 4'h0;
    localparam logic [3:0] IFACE_NOECHO = 4'h1;
    localparam logic [3:0] IFACE_MAX = 4'h9;
    localparam logic [7:0] ADDR_DEFAULT = 8'h41;
    localparam logic [7:0] ADDR_MIN = 8'h21;
    // Firmware revision; arbitrary values
    localparam logic [7:0] REV_MAJOR_RST = 8'h01;
    localparam logic [7:0] REV_MINOR_RST = 8'h00;

    // Command characters
    localparam logic [7:0] CH_ADC = 8'h64;
    localparam logic [7:0] CH_SAVE = 8'h57;
    localparam logic [7:0] CH_ENA = 8'h45;
    localparam logic [7:0] CH_IFACE = 8'h59;
    localparam logic [7:0] CH_ADDR = 8'h5a;
    localparam logic [7:0] CH_HELP = 8'h3f;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_SP = 8'h20;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [9:0] ARG_SAT = 10'h3ff;

    typedef enum logic [3:0] {
        MSG_BANNER = 4'h0,
        MSG_ADC = 4'h1,
        MSG_WRITE = 4'h2,
        MSG_ENA = 4'h3,
        MSG_DIS = 4'h4,
        MSG_HELP = 4'h5,
        MSG_OVL = 4'h6,
        MSG_OVT = 4'h7,
        MSG_UVL = 4'h8
    } acc_msg_t;
    localparam int NUM_MSG = 9;

    typedef struct packed {
        logic storeEn;
        logic [3:0] iface;
        logic [7:0] addr;
    } acc_param_t;

    typedef struct packed {
        logic [7:0] temp;
        logic [7:0] volt;
        logic [7:0] revMaj;
        logic [7:0] revMin;
        acc_param_t prm;
    } acc_vals_t;

    // Texts; bytes 8'h11 to 8'h1d stand for value digits
    localparam int TXT_W = 384;
    localparam logic [8*9-1:0] S_BANNER = "Ctl V\034.\035\n";
    localparam logic [8*22-1:0] S_ADC = "TEMP = \021\022\023 VOLT = \024\025\026\n";
    localparam logic [8*9-1:0] S_WRITE = "Write EE\n";
    localparam logic [8*10-1:0] S_ENA = "Enable EE\n";
    localparam logic [8*11-1:0] S_DIS = "Disable EE\n";
    localparam logic [8*35-1:0] S_HELP =
        "d W E Y0-9 Z33-255 ?\nE=\033 Y=\027 Z=\030\031\032\n";
    localparam logic [8*10-1:0] S_OVL = "Overload!\n";
    localparam logic [8*17-1:0] S_OVT = "Overtemperature!\n";
    localparam logic [8*14-1:0] S_UVL = "Undervoltage!\n";
    localparam logic [5:0] L_BANNER = 6'h09;
    localparam logic [5:0] L_ADC = 6'h16;
    localparam logic [5:0] L_WRITE = 6'h09;
    localparam logic [5:0] L_ENA = 6'h0a;
    localparam logic [5:0] L_DIS = 6'h0b;
    localparam logic [5:0] L_HELP = 6'h23;
    localparam logic [5:0] L_OVL = 6'h0a;
    localparam logic [5:0] L_OVT = 6'h11;
    localparam logic [5:0] L_UVL = 6'h0e;

endpackage

//--- verilog/acc_text.sv
// Message text lookup: one character of a message with values filled in.
// Assumes the caller holds msgId and idx stable while it reads ch.
`timescale 1ns/1ns
module acc_text (
    input wire acc_pkg::acc_msg_t msgId,
    input wire logic [5:0] idx,
    input wire acc_pkg::acc_vals_t vals,
    output logic [7:0] ch,
    output logic last
);

    function automatic logic [7:0] pick(
        input logic [acc_pkg::TXT_W-1:0] s,
        input logic [5:0] len,
        input logic [5:0] pos
    );
        int bitPos;
        bitPos = (int'(len) - int'(pos) - 1) * 8;
        return s[bitPos +: 8];
    endfunction

    // Decimal digit of a byte: 2 hundreds, 1 tens, 0 ones
    function automatic logic [7:0] digit(
        input logic [7:0] v,
        input logic [1:0] sel
    );
        logic [7:0] d;
        d = 8'h00;
        unique case (sel)
            2'h2: d = v / 8'h64;
            2'h1: d = (v / 8'h0a) % 8'h0a;
            default: d = v % 8'h0a;
        endcase
        return acc_pkg::CH_ZERO + d;
    endfunction

    logic [7:0] raw;
    logic [5:0] len;

    always_comb
    begin
        raw = 8'h00;
        len = 6'h01;
        unique case (msgId)
            acc_pkg::MSG_BANNER:
            begin
                len = acc_pkg::L_BANNER;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_BANNER), len, idx);
            end
            acc_pkg::MSG_ADC:
            begin
                len = acc_pkg::L_ADC;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_ADC), len, idx);
            end
            acc_pkg::MSG_WRITE:
            begin
                len = acc_pkg::L_WRITE;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_WRITE), len, idx);
            end
            acc_pkg::MSG_ENA:
            begin
                len = acc_pkg::L_ENA;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_ENA), len, idx);
            end
            acc_pkg::MSG_DIS:
            begin
                len = acc_pkg::L_DIS;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_DIS), len, idx);
            end
            acc_pkg::MSG_HELP:
            begin
                len = acc_pkg::L_HELP;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_HELP), len, idx);
            end
            acc_pkg::MSG_OVL:
            begin
                len = acc_pkg::L_OVL;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_OVL), len, idx);
            end
            acc_pkg::MSG_OVT:
            begin
                len = acc_pkg::L_OVT;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_OVT), len, idx);
            end
            acc_pkg::MSG_UVL:
            begin
                len = acc_pkg::L_UVL;
                raw = pick(acc_pkg::TXT_W'(acc_pkg::S_UVL), len, idx);
            end
            default:
            begin
                len = 6'h01;
                raw = acc_pkg::CH_LF;
            end
        endcase
    end

    always_comb
    begin
        last = (idx == len - 6'h01);
        unique case (raw)
            8'h11: ch = digit(vals.temp, 2'h2);
            8'h12: ch = digit(vals.temp, 2'h1);
            8'h13: ch = digit(vals.temp, 2'h0);
            8'h14: ch = digit(vals.volt, 2'h2);
            8'h15: ch = digit(vals.volt, 2'h1);
            8'h16: ch = digit(vals.volt, 2'h0);
            8'h17: ch = acc_pkg::CH_ZERO + {4'h0, vals.prm.iface};
            8'h18: ch = digit(vals.prm.addr, 2'h2);
            8'h19: ch = digit(vals.prm.addr, 2'h1);
            8'h1a: ch = digit(vals.prm.addr, 2'h0);
            8'h1b: ch = acc_pkg::CH_ZERO + {7'h00, vals.prm.storeEn};
            8'h1c: ch = digit(vals.revMaj, 2'h0);
            8'h1d: ch = digit(vals.revMin, 2'h0);
            default: ch = raw;
        endcase
    end

endmodule // acc_text

//--- verif/acc_checker.sv
// Checker: concurrent properties on the ports of acc_cmd_tail.
// Assumes one clock domain; bound into every acc_cmd_tail below.
`timescale 1ns/1ns
module acc_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] rxData,
    input wire logic rxValid,
    input wire logic rxReady,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic overCurrent,
    input wire acc_pkg::acc_param_t nvRdData,
    input wire acc_pkg::acc_param_t nvWrData,
    input wire logic nvWrite,
    input wire logic nvFlagWrite,
    input wire acc_pkg::acc_param_t linkCfg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence takeSave;
        rxValid && rxReady && rxData == acc_pkg::CH_SAVE;
    endsequence
    sequence takeToggle;
        rxValid && rxReady && rxData == acc_pkg::CH_ENA;
    endsequence
    sequence quietBoot;
        !txValid [*8];
    endsequence

    a_save_pulse: assert property (takeSave |=> nvWrite
        && nvWrData == $past(linkCfg))
        else $error("save pulse or data wrong");
    a_toggle_flag: assert property (takeToggle |-> ##[1:2] nvFlagWrite)
        else $error("flag write missing after toggle");
    a_flag_alone: assert property (nvFlagWrite |-> !nvWrite)
        else $error("flag write overlaps full write");
    a_take_drop: assert property (rxValid && rxReady |=> !rxReady)
        else $error("ready stayed high after take");
    a_tx_hold: assert property (txValid && !txReady |=> txValid
        && $stable(txData))
        else $error("tx byte dropped while stalled");
    a_boot_cfg: assert property ($rose(resetn) |-> linkCfg ==
        {1'b0, acc_pkg::IFACE_DEFAULT, acc_pkg::ADDR_DEFAULT})
        else $error("settings not at defaults in reset");
    a_boot_load: assert property ($rose(resetn) |-> ##[1:2] linkCfg ==
        (nvRdData.storeEn ? nvRdData : acc_pkg::acc_param_t'({1'b0,
        acc_pkg::IFACE_DEFAULT, acc_pkg::ADDR_DEFAULT})))
        else $error("power-on load wrong");
    a_no_banner: assert property ($rose(resetn) && nvRdData.storeEn
        && nvRdData.iface > acc_pkg::IFACE_NOECHO |-> quietBoot)
        else $error("banner sent on two-wire link");
    a_iface_legal: assert property (linkCfg.iface <= acc_pkg::IFACE_MAX)
        else $error("interface value out of range");
    a_addr_legal: assert property (linkCfg.addr >= acc_pkg::ADDR_MIN)
        else $error("address letter out of range");
    a_err_report: assert property ($rose(overCurrent) |->
        ##[1:1000] txValid && txData == 8'h4f)
        else $error("overload message missing");
endmodule // acc_checker

bind acc_cmd_tail acc_checker acc_checker_inst (
    .clk(clk), .resetn(resetn), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .txData(txData), .txValid(txValid),
    .txReady(txReady), .overCurrent(overCurrent), .nvRdData(nvRdData),
    .nvWrData(nvWrData), .nvWrite(nvWrite), .nvFlagWrite(nvFlagWrite),
    .linkCfg(linkCfg)
);

//--- verif/acc_host_model.sv
// Host model: offers command bytes and sinks replies.
// Assumes the design's byte handshake on a shared clk.
`timescale 1ns/1ns
module acc_host_model (
    input wire logic clk,
    input wire logic rxReady,
    input wire logic slow,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic txReady
);
    logic [1:0] stallCnt = 2'h0;

    initial
    begin
        rxData = 8'h00;
        rxValid = 1'b0;
    end

    // Sink stalls three cycles of four when slow
    always @(posedge clk)
    begin
        stallCnt <= stallCnt + 2'h1;
        txReady <= !slow || stallCnt == 2'h0;
    end

    // Offer one byte, hold until taken, then scramble the line
    task sendByte(input logic [7:0] b);
        @(posedge clk);
        rxData <= b;
        rxValid <= 1'b1;
        @(posedge clk);
        for (int n = 0; n < 5000 && rxReady !== 1'b1; n++)
            @(posedge clk);
        rxValid <= 1'b0;
        rxData <= ~b;
    endtask
endmodule // acc_host_model

//--- verif/tb_top.sv
// Testbench: commands, settings, errors and power cycles of acc_cmd_tail.
// Assumes acc_pkg, the design, the host model and the checker compiled.
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0, resetn = 1'b0, slow = 1'b0, echo = 1'b1;
    logic overCurrent = 1'b0, overTemp = 1'b0, underVolt = 1'b0;
    logic regWr = 1'b0, regRd = 1'b0, rdPend = 1'b0;
    logic rxValid, rxReady, txValid, txReady, nvWrite, nvFlagWrite;
    logic [7:0] rxData, txData, expByte;
    logic [7:0] tempAdc = 8'h00, voltAdc = 8'h00, regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0, regRdData;
    acc_pkg::acc_param_t nvRdData = 13'h0733, nvWrData, linkCfg, wrSeen;
    logic [7:0] expQ[$];
    logic [31:0] rdQ[$];
    integer seed = 35;
    int miscompares = 0, numChecks = 0, nWr = 0, nFlag = 0, zv;
    string seqTxt[8] = '{"Y9\r", "Y10\r", "Z33\r", "Z32\r", "Z255\r",
        "Z1000\r", "Y\r", "Y1\r"};
    logic [11:0] seqExp[8] = '{12'h941, 12'h941, 12'h921, 12'h921,
        12'h9ff, 12'h9ff, 12'h9ff, 12'h1ff};

    acc_cmd_tail acc_cmd_tail_inst (
        .clk(clk), .resetn(resetn), .rxData(rxData), .rxValid(rxValid),
        .rxReady(rxReady), .txData(txData), .txValid(txValid),
        .txReady(txReady), .tempAdc(tempAdc), .voltAdc(voltAdc),
        .overCurrent(overCurrent), .overTemp(overTemp),
        .underVolt(underVolt), .nvRdData(nvRdData), .nvWrData(nvWrData),
        .nvWrite(nvWrite), .nvFlagWrite(nvFlagWrite), .linkCfg(linkCfg),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData)
    );
    acc_host_model acc_host_model_inst (
        .clk(clk), .rxReady(rxReady), .slow(slow), .rxData(rxData),
        .rxValid(rxValid), .txReady(txReady)
    );

    always #5 clk = ~clk;

    task check(input string what, input logic [31:0] seen, exp);
        numChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task finish_test;
        $display("checks %0d miscompares %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Output watcher: takes the oldest note whenever a result appears
    always @(posedge clk)
    begin
        if (resetn && txValid && txReady)
        begin
            expByte = expQ.size() > 0 ? expQ.pop_front() : 8'h00;
            check("tx byte", txData, expByte);
        end
        if (rdPend)
            check("reg read", regRdData, rdQ.pop_front());
        rdPend = regRd;
        nWr += nvWrite;
        nFlag += nvFlagWrite;
        if (nvWrite)
            wrSeen = nvWrData;
    end

    task push(input string s);
        for (int i = 0; i < s.len(); i++)
            expQ.push_back(s[i]);
    endtask

    task drain;
        for (int n = 0; n < 4000 && (expQ.size() > 0 || txValid); n++)
            @(posedge clk);
        repeat (4) @(posedge clk);
    endtask

    task cmd(input string s, input string msg);
        if (echo)
            push(s);
        push(msg);
        for (int i = 0; i < s.len(); i++)
            acc_host_model_inst.sendByte(s[i]);
        drain();
    endtask

    task regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task regRead(input logic [7:0] a, input logic [31:0] e);
        rdQ.push_back(e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
    endtask

    task powerUp(input acc_pkg::acc_param_t img);
        @(posedge clk);
        resetn <= 1'b0;
        nvRdData <= img;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (40) @(posedge clk);
        drain();
    endtask

    initial
    begin
        push($sformatf("Ctl V%0d.%0d\n", acc_pkg::REV_MAJOR_RST,
            acc_pkg::REV_MINOR_RST));
        powerUp(13'h0733);
        check("boot cfg", linkCfg, 13'h0041);
        regRead(acc_pkg::ADDR_REV, {16'h0, acc_pkg::REV_MAJOR_RST,
            acc_pkg::REV_MINOR_RST});
        regRead(acc_pkg::ADDR_CFG, 32'h0000_4100);
        regRead(8'h0c, 32'h0);
        slow <= 1'b1;
        tempAdc <= 8'($random(seed));
        voltAdc <= 8'($random(seed));
        @(posedge clk);
        cmd("d", $sformatf("TEMP = %03d VOLT = %03d\n", tempAdc, voltAdc));
        cmd("E", "Enable EE\n");
        regRead(acc_pkg::ADDR_STATUS, 32'h0000_0010);
        cmd("W", "Write EE\n");
        check("save data", wrSeen, 13'h1041);
        cmd("E", "Disable EE\n");
        check("flag writes", nFlag, 2);
        cmd("?", "d W E Y0-9 Z33-255 ?\nE=0 Y=0 Z=065\n");
        slow <= 1'b0;
        echo = 1'b0;
        regWrite(acc_pkg::ADDR_CFG, 32'h0000_4101);
        regWrite(acc_pkg::ADDR_CFG, 32'h0000_410a);
        regRead(acc_pkg::ADDR_CFG, 32'h0000_4101);
        for (int i = 0; i < 8; i++)
        begin
            cmd(seqTxt[i], "");
            check(seqTxt[i], linkCfg[11:0], seqExp[i]);
        end
        zv = 33 + ({$random(seed)} % 223);
        // Switch to the two-wire link, save, enable, cycle power
        cmd($sformatf("Z%0d\r", zv), "");
        cmd("Y9\r", "");
        cmd("W", "Write EE\n");
        cmd("E", "Enable EE\n");
        check("save count", nWr, 2);
        check("saved image", wrSeen, {5'h09, zv[7:0]});
        push("Overload!\nOvertemperature!\nUndervoltage!\n");
        {overCurrent, overTemp, underVolt} <= 3'h7;
        drain();
        {overCurrent, overTemp, underVolt} <= 3'h0;
        powerUp({5'h19, zv[7:0]});
        check("stored cfg", linkCfg, {5'h19, zv[7:0]});
        check("notes left", expQ.size(), 0);
        finish_test();
    end

    initial
    begin
        #500000;
        miscompares++;
        finish_test();
    end
endmodule // tb_top
